/* File: csa_axis.sv */
// Stepper axis: trajectory, loop filter and step generator.
// Assumes inputs synchronous to mclk_i.
//
// Contract
// RQ1: Closed loop reports encoder counter as position.
// RQ2: Quadrature decode gives four counts per line.
// RQ3: Closed loop targets are in encoder counts.
// RQ4: Ratio converts encoder-unit command into steps.
// RQ5: Trajectory in encoder units, loaded before moves.
// RQ6: Closed loop gains default P 0.0001, others zero.
// RQ7: Mode takes effect and positions reset on re-enable.
// RQ8: Error above limit flags fault, stops axis.
// RQ9: Reversed phase inverts the direction output.
// RQ10: Open loop counts issued steps as position.
// RQ11: Single-ended encoder works, complements unused.
// RQ12: Host should use proportional gain only.
// RQ13: Step generator off within one microsecond.
// RQ14: Never drive back after overshooting target.
// RQ15: Capture and compare disabled in closed loop.
// RQ16: Step rate from velocity plus error, scaled, clamped.
`timescale 1ns/10ps
`default_nettype none
module csa_axis (
  input  wire logic               mclk_i,        // Controller clock.
  input  wire logic               rstn_i,        // Async reset, active low.
  input  wire csa_pkg::csa_enc_t  enc_i,         // Encoder phases.
  input  wire logic               axis_en_i,     // Axis enable level.
  input  wire logic               closed_loop_i, // Closed loop selected.
  input  wire logic               reversed_output_phase_i, // Flip dir.
  input  wire logic               step_range_hi_i, // High speed range.
  input  wire logic               cfg_wr_i,      // Load cfg_i, pulse.
  input  wire csa_pkg::csa_cfg_t  cfg_i,         // New configuration.
  input  wire logic               move_i,        // Start a move, pulse.
  input  wire logic signed [31:0] target_i,      // Absolute target.
  input  wire logic               capture_i,     // Capture position, pulse.
  input  wire logic signed [31:0] compare_pos_i, // Compare position.
  output var  logic               step_o,        // Step pulse.
  output var  logic               dir_o,         // Direction to driver.
  output var  logic signed [31:0] position_o,    // Reported position.
  output var  logic               motor_error_o, // Following error trip.
  output var  logic               busy_o,        // Move in progress.
  output var  logic               closed_o,      // Closed loop active.
  output var  logic signed [31:0] capture_pos_o, // Captured position.
  output var  logic               compare_hit_o  // Position equals compare.
);

  localparam int LW = csa_pkg::LOOP_W;
  localparam int FW = csa_pkg::FRAC_W;
  localparam int NS = csa_pkg::NCO_SHIFT;
  localparam logic [LW-1:0] TICK_LAST = LW'(csa_pkg::LOOP_CYCLES - 1);

  // Loop group state.
  csa_pkg::csa_state_t state_ff, nxt_state;     // Motion state.
  csa_pkg::csa_cfg_t   cfg_ff, nxt_cfg;         // Live configuration.
  logic                en_q_ff, nxt_en_q;       // Enable seen last cycle.
  logic                mode_ff, nxt_mode;       // Latched closed loop.
  logic                err_ff, nxt_err;         // Sticky motor error.
  logic                dir_ff, nxt_dir;         // Move sense, 1 forward.
  logic signed [31:0]  tgt_ff, nxt_tgt;         // Move target.
  logic signed [47:0]  traj_ff, nxt_traj;       // Ideal position Q32.16.
  logic [31:0]         vel_ff, nxt_vel;         // Ideal speed magnitude.
  logic signed [31:0]  integ_ff, nxt_integ;     // Error sum.
  logic signed [31:0]  perr_ff, nxt_perr;       // Error at last tick.
  logic [31:0]         inc_ff, nxt_inc;         // NCO increment.
  logic [LW-1:0]       tick_ff, nxt_tick;       // Loop tick counter.

  // Pulse group state.
  logic [31:0]         nco_ff, nxt_nco;         // NCO phase.
  logic signed [31:0]  stp_ff, nxt_stp;         // Issued step count.
  logic signed [31:0]  enc_ff, nxt_enc;         // Encoder count.
  logic                step_ff, nxt_step;
  logic                dir_o_ff, nxt_dir_o;
  logic signed [31:0]  pos_ff, nxt_pos;
  logic signed [31:0]  cap_ff, nxt_cap;
  logic                hit_ff, nxt_hit;

  // Shared decode.
  logic                cnt_up, cnt_dn;          // Decoder counts.
  logic                en_rise;                 // Axis re-enabled.
  logic                tick;                    // Loop sample instant.
  logic                arrived;                 // Move end reached.
  logic signed [31:0]  fb_pos;                  // Feedback position.
  logic signed [31:0]  traj_int;                // Ideal position, counts.
  logic signed [31:0]  pos_err;                 // Ideal minus feedback.
  logic [31:0]         err_mag;                 // Error magnitude.
  logic signed [31:0]  rem;                     // Ideal distance to go.
  logic [95:0]         v_sq;                    // Speed squared.
  logic [95:0]         brake;                   // Braking budget.
  logic [31:0]         vel_up;                  // Accelerated speed.
  logic signed [63:0]  pid;                     // Loop terms, Q.16.
  logic signed [63:0]  cmd;                     // Counts per tick, Q.16.
  logic signed [96:0]  scaled;                  // Steps per tick, Q.16.
  logic signed [96:0]  mag;                     // Speed along move.
  logic [31:0]         inc_lim;                 // Range ceiling.
  logic [32:0]         nco_sum;                 // Phase plus carry.

  csa_quad_dec u_dec (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .enc_i    (enc_i),
    .cnt_up_o (cnt_up),
    .cnt_dn_o (cnt_dn)
  );

  // Terms shared by both groups.
  always_comb
  begin
    en_rise  = axis_en_i && !en_q_ff;
    tick     = (tick_ff == TICK_LAST);
    fb_pos   = mode_ff ? enc_ff : stp_ff;        // [RQ1] [RQ10]
    traj_int = traj_ff[47:FW];
    pos_err  = traj_int - fb_pos;
    err_mag  = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    rem      = dir_ff ? (tgt_ff - traj_int) : (traj_int - tgt_ff);
    // Overshoot counts as arrival, so the motor is never sent back.
    if (mode_ff)
      arrived = dir_ff ? (enc_ff >= tgt_ff)
                       : (enc_ff <= tgt_ff);     // [RQ13] [RQ14]
    else
      arrived = (stp_ff == tgt_ff);              // [RQ10]
    v_sq   = {64'h0, vel_ff} * {64'h0, vel_ff};
    brake  = {64'h0, cfg_ff.decel} * {64'h0, 32'(rem)};
    brake  = brake << (FW + 1);
    vel_up = vel_ff + cfg_ff.accel;
    // Gains use 31 bits so the products stay signed.
    pid = $signed({1'b0, cfg_ff.kp[30:0]}) * pos_err +
          $signed({1'b0, cfg_ff.ki[30:0]}) * integ_ff +
          $signed({1'b0, cfg_ff.kd[30:0]}) * (pos_err - perr_ff);
    pid = pid >>> (csa_pkg::GAIN_FRAC_W - FW);
    cmd = dir_ff ? $signed({32'h0, vel_ff}) : -$signed({32'h0, vel_ff});
    if (mode_ff)
      cmd = cmd + pid;                           // [RQ16]
    // Counts become steps only in closed loop.
    if (mode_ff)
      scaled = (97'(cmd) * $signed({65'h0, cfg_ff.ratio})) >>> FW; // [RQ4]
    else
      scaled = 97'(cmd);
    mag     = dir_ff ? scaled : -scaled;
    inc_lim = step_range_hi_i ? csa_pkg::STEP_INC_HI
                              : csa_pkg::STEP_INC_LO;
  end

  // Next values of the loop group.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cfg   = cfg_ff;
    nxt_en_q  = axis_en_i;
    nxt_mode  = mode_ff;
    nxt_err   = err_ff;
    nxt_dir   = dir_ff;
    nxt_tgt   = tgt_ff;
    nxt_traj  = traj_ff;
    nxt_vel   = vel_ff;
    nxt_integ = integ_ff;
    nxt_perr  = perr_ff;
    nxt_inc   = inc_ff;
    nxt_tick  = tick ? '0 : tick_ff + 1'b1;
    // Configuration is only replaced while no move runs.
    if (cfg_wr_i && (state_ff != csa_pkg::ST_MOVE))
      nxt_cfg = cfg_i;                           // [RQ5]
    if (en_rise)
    begin
      // The new mode takes hold here.
      nxt_mode  = closed_loop_i;                 // [RQ7]
      nxt_state = csa_pkg::ST_IDLE;
      nxt_err   = 1'b0;
      nxt_traj  = '0;
      nxt_vel   = '0;
      nxt_integ = '0;
      nxt_perr  = '0;
      nxt_inc   = '0;
      nxt_tgt   = '0;
      if (closed_loop_i && !mode_ff)
      begin
        nxt_cfg.kp = csa_pkg::KP_RESET;          // [RQ6]
        nxt_cfg.ki = csa_pkg::KI_RESET;          // [RQ6]
        nxt_cfg.kd = csa_pkg::KD_RESET;          // [RQ6]
      end
    end
    else if (!axis_en_i)
    begin
      // A fault stays visible until the axis is enabled again.
      if (state_ff == csa_pkg::ST_MOVE)
        nxt_state = csa_pkg::ST_IDLE;
      nxt_vel = '0;
      nxt_inc = '0;
    end
    else
    begin
      case (state_ff)
        csa_pkg::ST_IDLE:
        begin
          // No move until a top speed is loaded.
          if (move_i && !err_ff && (cfg_ff.vmax != '0))
          begin
            nxt_state = csa_pkg::ST_MOVE;        // [RQ5]
            nxt_tgt   = target_i;                // [RQ3]
            nxt_dir   = (target_i >= fb_pos);
            nxt_traj  = {fb_pos, 16'h0000};
            nxt_vel   = '0;
            nxt_integ = '0;
            nxt_perr  = '0;
            nxt_inc   = '0;
          end
        end
        csa_pkg::ST_MOVE:
        begin
          if (mode_ff && (err_mag > cfg_ff.ferr_limit))
          begin
            nxt_state = csa_pkg::ST_FAULT;       // [RQ8]
            nxt_err   = 1'b1;                    // [RQ8]
            nxt_inc   = '0;
          end
          else if (arrived)
          begin
            // Checked every clock, well inside the stop delay.
            nxt_state = csa_pkg::ST_IDLE;        // [RQ13]
            nxt_inc   = '0;                      // [RQ13]
            nxt_vel   = '0;
          end
          else if (tick)
          begin
            // Trapezoid: brake once the stopping distance is reached.
            if (rem <= 0)
              nxt_vel = '0;
            else if (v_sq >= brake)
              nxt_vel = (vel_ff > cfg_ff.decel) ? vel_ff - cfg_ff.decel
                                                : '0;
            else if ((vel_up > cfg_ff.vmax) || (vel_up < vel_ff))
              nxt_vel = cfg_ff.vmax;
            else
              nxt_vel = vel_up;
            if ((rem > 0) && (nxt_vel < cfg_ff.vmin))
              nxt_vel = cfg_ff.vmin;
            if ((rem <= 0) || ($signed({16'h0, nxt_vel}) >=
                               $signed({rem, 16'h0000})))
              nxt_traj = {tgt_ff, 16'h0000};
            else if (dir_ff)
              nxt_traj = traj_ff + $signed({16'h0, nxt_vel});
            else
              nxt_traj = traj_ff - $signed({16'h0, nxt_vel});
            nxt_integ = integ_ff + pos_err;
            nxt_perr  = pos_err;
            // Backward demand is cut to zero, never reversed.
            if (mag <= 0)
              nxt_inc = '0;                      // [RQ14]
            else if (mag > $signed({65'h0, inc_lim >> NS}))
              nxt_inc = inc_lim;                 // [RQ16]
            else
              nxt_inc = mag[31:0] << NS;         // [RQ16]
          end
        end
        csa_pkg::ST_FAULT:
        begin
          nxt_inc = '0;                          // [RQ8]
          nxt_vel = '0;
        end
        default:
          nxt_state = csa_pkg::ST_IDLE;
      endcase
    end
  end

  // Loop group registers.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= csa_pkg::ST_IDLE;
      cfg_ff   <= {csa_pkg::RATIO_RESET, csa_pkg::KP_RESET,
                   csa_pkg::KI_RESET, csa_pkg::KD_RESET,
                   csa_pkg::FERR_RESET, csa_pkg::TRAJ_RESET,
                   csa_pkg::TRAJ_RESET, csa_pkg::TRAJ_RESET,
                   csa_pkg::TRAJ_RESET};
      en_q_ff  <= 1'b0;
      mode_ff  <= 1'b0;
      err_ff   <= 1'b0;
      dir_ff   <= 1'b1;
      tgt_ff   <= '0;
      traj_ff  <= '0;
      vel_ff   <= '0;
      integ_ff <= '0;
      perr_ff  <= '0;
      inc_ff   <= '0;
      tick_ff  <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cfg_ff   <= nxt_cfg;
      en_q_ff  <= nxt_en_q;
      mode_ff  <= nxt_mode;
      err_ff   <= nxt_err;
      dir_ff   <= nxt_dir;
      tgt_ff   <= nxt_tgt;
      traj_ff  <= nxt_traj;
      vel_ff   <= nxt_vel;
      integ_ff <= nxt_integ;
      perr_ff  <= nxt_perr;
      inc_ff   <= nxt_inc;
      tick_ff  <= nxt_tick;
    end
  end

  // Next values of the pulse group.
  always_comb
  begin
    nxt_nco  = '0;
    nxt_step = 1'b0;
    nxt_stp  = stp_ff;
    nxt_enc  = enc_ff;
    nxt_cap  = cap_ff;
    // The increment ceiling keeps pulses at least one cycle apart.
    if ((state_ff == csa_pkg::ST_MOVE) && axis_en_i && !arrived)
    begin
      nco_sum  = {1'b0, nco_ff} + {1'b0, inc_ff};
      nxt_nco  = nco_sum[31:0];
      nxt_step = nco_sum[32];
    end
    else
      nco_sum = '0;                              // [RQ13]
    if (nxt_step)
      nxt_stp = dir_ff ? stp_ff + 1 : stp_ff - 1; // [RQ10]
    if (cnt_up && !cnt_dn)
      nxt_enc = enc_ff + 1;                      // [RQ2]
    else if (cnt_dn && !cnt_up)
      nxt_enc = enc_ff - 1;                      // [RQ2]
    if (en_rise)
    begin
      nxt_stp  = '0;                             // [RQ7]
      nxt_enc  = '0;                             // [RQ7]
      nxt_nco  = '0;
      nxt_step = 1'b0;
    end
    nxt_dir_o = dir_ff ^ reversed_output_phase_i; // [RQ9]
    nxt_pos   = mode_ff ? nxt_enc : nxt_stp;     // [RQ1] [RQ10]
    // Capture and compare serve open loop only.
    if (capture_i && !mode_ff)
      nxt_cap = fb_pos;                          // [RQ15]
    nxt_hit = !mode_ff && (fb_pos == compare_pos_i); // [RQ15]
  end

  // Pulse group registers.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      nco_ff   <= '0;
      stp_ff   <= '0;
      enc_ff   <= '0;
      step_ff  <= 1'b0;
      dir_o_ff <= 1'b0;
      pos_ff   <= '0;
      cap_ff   <= '0;
      hit_ff   <= 1'b0;
    end
    else
    begin
      nco_ff   <= nxt_nco;
      stp_ff   <= nxt_stp;
      enc_ff   <= nxt_enc;
      step_ff  <= nxt_step;
      dir_o_ff <= nxt_dir_o;
      pos_ff   <= nxt_pos;
      cap_ff   <= nxt_cap;
      hit_ff   <= nxt_hit;
    end
  end

  assign step_o        = step_ff;
  assign dir_o         = dir_o_ff;
  assign position_o    = pos_ff;
  assign motor_error_o = err_ff;
  assign busy_o        = (state_ff == csa_pkg::ST_MOVE);
  assign closed_o      = mode_ff;
  assign capture_pos_o = cap_ff;
  assign compare_hit_o = hit_ff;

endmodule
`default_nettype wire

/* File: csa_pkg.sv */
// Constants and carrier types of the stepper axis.
// Assumes one 100 MHz controller clock.
package csa_pkg;

  // Clock and control-loop timing.
  localparam int CLK_PERIOD_NS = 10;                    // Clock period.
  localparam int LOOP_TIME_NS  = 10240;                 // Loop sample time.
  localparam int LOOP_CYCLES   = LOOP_TIME_NS / CLK_PERIOD_NS;
  localparam int LOOP_W        = $clog2(LOOP_CYCLES);   // Tick counter width.
  localparam int STOP_TIME_NS  = 1000;                  // Longest stop delay.
  localparam int STOP_CYCLES   = STOP_TIME_NS / CLK_PERIOD_NS;

  // Fixed-point formats.
  localparam int FRAC_W      = 16;                      // Velocity, ratio.
  localparam int GAIN_FRAC_W = 24;                      // Loop gains.
  localparam int NCO_SHIFT   = 32 - FRAC_W - LOOP_W;    // Per tick to per clk.
  localparam int COUNTS_PER_LINE = 4;                   // Quadrature x4.

  // Reset values.
  localparam logic [31:0] KP_RESET    = 32'h0000_068E;  // 0.0001 in Q8.24.
  localparam logic [31:0] KI_RESET    = 32'h0000_0000;
  localparam logic [31:0] KD_RESET    = 32'h0000_0000;
  localparam logic [31:0] FERR_RESET  = 32'h0000_0400;  // 1024 counts.
  localparam logic [31:0] RATIO_RESET = 32'h0001_0000;  // 1.0 in Q16.16.
  localparam logic [31:0] TRAJ_RESET  = 32'h0000_0000;  // Must be loaded.

  // Highest NCO increment for each step range.
  localparam logic [31:0] STEP_INC_HI = 32'h8000_0000;
  localparam logic [31:0] STEP_INC_LO = 32'h0080_0000;

  // Axis configuration, written as one word.
  typedef struct packed {
    logic [31:0] ratio;      // Steps per encoder count, Q16.16.
    logic [31:0] kp;         // Proportional gain, Q8.24.
    logic [31:0] ki;         // Integral gain, Q8.24.
    logic [31:0] kd;         // Derivative gain, Q8.24.
    logic [31:0] ferr_limit; // Following error limit in counts.
    logic [31:0] vmax;       // Counts per tick, Q16.16.
    logic [31:0] accel;      // Counts per tick per tick, Q16.16.
    logic [31:0] decel;      // Counts per tick per tick, Q16.16.
    logic [31:0] vmin;       // Counts per tick, Q16.16.
  } csa_cfg_t;

  // Single-ended quadrature phases.
  typedef struct packed {
    logic a;
    logic b;
  } csa_enc_t;

  // Axis motion state.
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_FAULT} csa_state_t;

endpackage

/* File: csa_quad_dec.sv */
// Quadrature decoder, one count per phase edge.
// Assumes phases synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module csa_quad_dec (
  input  wire logic            mclk_i,    // Controller clock.
  input  wire logic            rstn_i,    // Asynchronous reset, active low.
  input  wire csa_pkg::csa_enc_t enc_i,   // Phase A and B.
  output var  logic            cnt_up_o,  // One count forward.
  output var  logic            cnt_dn_o   // One count backward.
);

  logic [1:0] prev_ff;      // Phases seen last cycle.
  logic       up_ff;        // Registered forward pulse.
  logic       dn_ff;        // Registered backward pulse.
  logic       nxt_up;
  logic       nxt_dn;
  logic [3:0] trans;        // Old and new phase pair.

  // Every legal edge of either phase is one count, four per line, so a
  // 500 line encoder gives 2000 counts a turn. Double jumps are dropped
  // since their direction cannot be known.
  always_comb
  begin
    trans  = {prev_ff, enc_i.a, enc_i.b};
    nxt_up = (trans == 4'h1) || (trans == 4'h7) ||
             (trans == 4'hE) || (trans == 4'h8);      // [RQ2]
    nxt_dn = (trans == 4'h2) || (trans == 4'hB) ||
             (trans == 4'hD) || (trans == 4'h4);      // [RQ2]
  end

  // Registers only; the true phases alone drive the decode. [RQ11]
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prev_ff <= 2'h0;
      up_ff   <= 1'b0;
      dn_ff   <= 1'b0;
    end
    else
    begin
      prev_ff <= {enc_i.a, enc_i.b};
      up_ff   <= nxt_up;
      dn_ff   <= nxt_dn;
    end
  end

  assign cnt_up_o = up_ff;
  assign cnt_dn_o = dn_ff;

endmodule
`default_nettype wire

/* File: csa_axis_properties.sv */
// Concurrent checks on the stepper axis ports.
// Assumes a bind into csa_axis, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module csa_axis_properties (
  input wire logic               mclk_i,        // Clock.
  input wire logic               rstn_i,        // Reset, active low.
  input wire logic               axis_en_i,     // Enable level.
  input wire logic               closed_loop_i, // Mode request.
  input wire logic               reversed_output_phase_i, // Flip dir.
  input wire logic               move_i,        // Move pulse.
  input wire logic signed [31:0] target_i,      // Move target.
  input wire logic               capture_i,     // Capture pulse.
  input wire logic               step_o,        // Step pulse.
  input wire logic               dir_o,         // Direction.
  input wire logic signed [31:0] position_o,    // Reported position.
  input wire logic               motor_error_o, // Error flag.
  input wire logic               busy_o,        // Move running.
  input wire logic               closed_o,      // Mode in force.
  input wire logic signed [31:0] capture_pos_o, // Captured value.
  input wire logic               compare_hit_o  // Compare hit.
);
  // One domain: clock and reset given once.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // No enable rise, not the reset release edge.
  sequence s_quiet;
    $past(rstn_i) && !$rose(axis_en_i);
  endsequence
  // Two idle cycles in a row.
  sequence s_idle2;
    !busy_o ##1 !busy_o;
  endsequence

  property p_reinit;
    $rose(axis_en_i) |=> position_o == 32'sh0000_0000 && !motor_error_o
      && closed_o == $past(closed_loop_i);
  endproperty
  property p_mode_hold;
    s_quiet |=> $stable(closed_o);
  endproperty
  property p_err_sticky;
    motor_error_o && !$rose(axis_en_i) |=> motor_error_o;
  endproperty
  property p_err_stop;
    $rose(motor_error_o) |-> !busy_o ##1 (!step_o)[*4];
  endproperty
  // Off within 100 cycles, one microsecond.
  property p_arrive;
    closed_o && busy_o && position_o == target_i |-> ##[1:100] !busy_o;
  endproperty
  property p_idle_quiet;
    s_idle2 |-> !step_o;
  endproperty
  property p_open_still;
    (!closed_o && !busy_o && !$rose(axis_en_i))[*3] |=> $stable(position_o);
  endproperty
  property p_dir_flip;
    s_quiet and ($changed(reversed_output_phase_i) && !busy_o && !move_i)
      |=> dir_o != $past(dir_o);
  endproperty
  property p_cap_closed;
    closed_o && !$rose(axis_en_i) |=> $stable(capture_pos_o) && !compare_hit_o;
  endproperty
  property p_cap_open;
    !closed_o && !busy_o && capture_i |=> capture_pos_o == position_o;
  endproperty

  a_reinit: assert property (p_reinit)
    else $error("reinit wrong");
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed");
  a_err_sticky: assert property (p_err_sticky)
    else $error("error dropped");
  a_err_stop: assert property (p_err_stop)
    else $error("no stop on error");
  a_arrive: assert property (p_arrive)
    else $error("no stop at target");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle step");
  a_open_still: assert property (p_open_still)
    else $error("open position moved");
  a_dir_flip: assert property (p_dir_flip)
    else $error("no direction flip");
  a_cap_closed: assert property (p_cap_closed)
    else $error("capture in closed loop");
  a_cap_open: assert property (p_cap_open)
    else $error("capture wrong");
endmodule
`default_nettype wire

/* File: csa_motor_model.sv */
// Behavioural stepper driver with a shaft-coupled quadrature encoder.
// Assumes one encoder count per step and phases timed to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module csa_motor_model (
  input  wire logic            mclk_i,      // Clock.
  input  wire logic            step_i,      // Step pulse from the axis.
  input  wire logic            dir_i,       // Direction from the axis.
  input  wire logic            wired_rev_i, // Motor wired reverse phased.
  input  wire logic            jog_i,       // Hand turn of one count.
  input  wire logic            jog_dir_i,   // Hand turn direction.
  output var  csa_pkg::csa_enc_t enc_o      // Single-ended phases.
);
  int pos = 0; // Shaft angle in encoder counts.

  // A reverse phased motor turns against the direction line.
  always @(posedge mclk_i)
  begin
    pos <= pos + ((step_i === 1'b1) ? ((dir_i ^ wired_rev_i) ? 1 : -1) : 0)
               + ((jog_i === 1'b1) ? (jog_dir_i ? 1 : -1) : 0);
  end

  // Four states a line, B leads going forward; no complements.
  always_comb
  begin
    enc_o = '{a: pos[1], b: pos[1] ^ pos[0]};
  end
endmodule
`default_nettype wire

/* File: csa_axis_tb_top.sv */
// Self-checking bench of the stepper axis and a motor model.
// Assumes the package compiles first.
`timescale 1ns/10ps
`default_nettype none
module csa_axis_tb_top;
  logic               mclk_i = 1'b0; // Controller clock.
  logic               rstn_i = 1'b0; // Reset, active low.
  csa_pkg::csa_enc_t  enc;           // Phases from the model.
  csa_pkg::csa_cfg_t  cfg = '0;      // Axis configuration.
  logic               en = 1'b0, cl = 1'b0, rph = 1'b0, cfg_wr = 1'b0;
  logic               mv = 1'b0, cap = 1'b0, jog = 1'b0, jdir = 1'b0;
  logic               wrev = 1'b0;   // Motor wired reverse phased.
  logic signed [31:0] tgt = '0, cmp = '0;
  logic               step, dir, merr, busy, closed, hit;
  logic signed [31:0] pos, cpos;
  int                 n_fail = 0, n_tests = 0;
  int                 sc = 0, ec = 0; // Reference step and encoder counts.
  int                 tq[$];          // Open loop targets to revisit.
  int                 t;

  always #5 mclk_i = ~mclk_i;

  csa_axis uut (.mclk_i, .rstn_i, .enc_i(enc),
    .axis_en_i(en), .closed_loop_i(cl), .reversed_output_phase_i(rph),
    .step_range_hi_i(1'b1), .cfg_wr_i(cfg_wr), .cfg_i(cfg), .move_i(mv),
    .target_i(tgt), .capture_i(cap), .compare_pos_i(cmp), .step_o(step),
    .dir_o(dir), .position_o(pos), .motor_error_o(merr), .busy_o(busy),
    .closed_o(closed), .capture_pos_o(cpos), .compare_hit_o(hit));
  csa_motor_model motor (.mclk_i, .step_i(step), .dir_i(dir),
    .wired_rev_i(wrev), .jog_i(jog), .jog_dir_i(jdir), .enc_o(enc));

  // Reference: steps by commanded sense, shaft by wiring.
  always @(posedge mclk_i)
  begin
    if (step === 1'b1)
    begin
      sc += (dir ^ rph) ? 1 : -1;
      ec += (dir ^ wrev) ? 1 : -1;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // Counts per tick; proportional gain only.
  task automatic load(input logic [31:0] ferr);
    cfg = '{ratio: csa_pkg::RATIO_RESET, kp: csa_pkg::KP_RESET,
      ki: 32'h0000_0000, kd: 32'h0000_0000, ferr_limit: ferr,
      vmax: 32'h0010_0000, accel: 32'h0004_0000, decel: 32'h0004_0000,
      vmin: 32'h0002_0000};
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask
  // A mode change needs a disable, then an enable.
  task automatic enable(input logic m);
    en = 1'b0;
    tick(1);
    cl = m;
    en = 1'b1;
    tick(1);
    sc = 0;
    ec = 0;
    tick(1);
    chk_bit(closed, m);
    chk_val(pos, 32'h0000_0000);
    chk_bit(merr, 1'b0);
  endtask
  task automatic jog_n(input int n, input logic d);
    jdir = d;
    repeat (n)
    begin
      jog = 1'b1;
      tick(1);
      ec += d ? 1 : -1;
      jog = 1'b0;
      tick(1);
    end
    tick(4);
  endtask
  // Move, wait for the end, then see that no step follows.
  task automatic move_to(input int tt);
    int k, s;
    tgt = tt;
    mv = 1'b1;
    tick(1);
    mv = 1'b0;
    tick(1);
    for (k = 0; k < 30000 && busy === 1'b1; k++) tick(1);
    if (k == 30000)
    begin
      n_fail++;
      $display("[FAIL] %0t move never ended", $time);
    end
    s = sc;
    tick(200);
    chk_val(32'(sc), 32'(s));
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hd58f_d154));
    tick(6);
    rstn_i = 1'b1;
    tick(1);
    chk_bit(busy, 1'b0);
    load(csa_pkg::FERR_RESET);
    enable(1'b0);
    t = 8 + $urandom_range(23);
    tq.push_back(t);
    move_to(t);
    chk_val(pos, 32'(t));
    chk_val(pos, 32'(sc));
    jog_n(4, 1'b1);
    chk_val(pos, 32'(sc)); // Shaft turns are ignored.
    cap = 1'b1;
    cmp = t;
    tick(1);
    cap = 1'b0;
    tick(2);
    chk_val(cpos, 32'(t));
    chk_bit(hit, 1'b1);
    enable(1'b1);
    jog_n(4, 1'b1);
    chk_val(pos, 32'h0000_0004); // One line gives four counts.
    jog_n(4, 1'b0);
    chk_val(pos, 32'(ec));
    t = 20 + $urandom_range(31);
    move_to(t); // Target given in counts.
    chk_val(pos, 32'(ec));
    chk_bit(pos >= t, 1'b1);
    cap = 1'b1;
    tick(1);
    cap = 1'b0;
    tick(2);
    chk_val(cpos, 32'(tq.pop_front()));
    chk_bit(hit, 1'b0);
    load(32'h0000_0010);
    wrev = 1'b1;
    enable(1'b1);
    move_to(200);
    chk_bit(merr, 1'b1); // Runaway trips the error.
    chk_bit(busy, 1'b0);
    load(csa_pkg::FERR_RESET);
    rph = 1'b1;
    enable(1'b1);
    t = 20 + $urandom_range(31);
    move_to(t);
    chk_val(pos, 32'(ec));
    chk_bit(pos >= t, 1'b1);
    chk_bit(merr, 1'b0);
    enable(1'b0);
    test_done;
  end

  // The run needs about a third of this span; a hang ends here.
  initial
  begin
    #600_000;
    n_fail++;
    $display("[FAIL] %0t watchdog", $time);
    test_done;
  end
endmodule

bind csa_axis csa_axis_properties u_props (.mclk_i, .rstn_i, .axis_en_i,
  .closed_loop_i, .reversed_output_phase_i, .move_i, .target_i,
  .capture_i, .step_o, .dir_o, .position_o, .motor_error_o, .busy_o,
  .closed_o, .capture_pos_o, .compare_hit_o);
`default_nettype wire
